// ===== design/afeho_pkg.sv
// afeho_pkg: constants for the scanner front-end host-side logic.
// assumes a single 100 MHz system clock; all pins sampled into it.
package afeho_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned DATA_W = 10;
    localparam int unsigned REG_NUM_W = 5;
    localparam int unsigned NUM_REGS = 32;
    localparam int unsigned LONG_CYCLES = 17;
    localparam int unsigned SHORT_CYCLES = 16;
    localparam int unsigned LONG_CANCEL_MAX = 15;
    localparam int unsigned SHORT_CANCEL_MAX = 14;
    localparam int unsigned LONG_OK_MAX = 25;
    localparam int unsigned SHORT_OK_MAX = 24;
    localparam int unsigned BIT_CNT_W = 6;
    // register numbers of the bank
    localparam logic [4:0] REG_POWER_SAVE = 5'h00;
    localparam logic [4:0] REG_DATA_CONTROL = 5'h03;
    localparam logic [4:0] REG_PIXEL_BOUNDARY = 5'h04;
    localparam logic [4:0] REG_BLACK_COUNT = 5'h05;
    localparam logic [4:0] REG_WHITE_COUNT_HI = 5'h06;
    localparam logic [4:0] REG_WHITE_COUNT_LO = 5'h07;
    localparam logic [4:0] REG_FRONTEND_CONTROL = 5'h0b;
    localparam logic [4:0] REG_OFFSET_RED = 5'h10;
    localparam logic [4:0] REG_OFFSET_GREEN = 5'h12;
    localparam logic [4:0] REG_OFFSET_BLUE = 5'h14;
    // power save register fields
    localparam int unsigned PS_TX_BIT = 0;
    localparam int unsigned PS_SHAPER_BIT = 1;
    // data control register fields
    localparam int unsigned DC_MUX_BIT = 0;
    localparam int unsigned DC_ORDER_BIT = 1;
    localparam int unsigned DC_AVG_BIT = 2;
    localparam int unsigned DC_NULL_R_BIT = 3;
    localparam int unsigned DC_NULL_G_BIT = 4;
    localparam int unsigned DC_NULL_B_BIT = 5;
    localparam int unsigned DC_START_BIT = 6;
    localparam int unsigned DC_TEST_LSB = 8;
    localparam logic [9:0] NULL_CODE = 10'h000;
    localparam logic [1:0] TP_OFF = 2'h0;
    localparam logic [1:0] TP_COLOUR = 2'h1;
    localparam logic [1:0] TP_COUNT = 2'h2;
    localparam logic [1:0] TP_FIXED = 2'h3;
    localparam logic [1:0] COLOUR_RED = 2'h0;
    localparam logic [1:0] COLOUR_GREEN = 2'h1;
    localparam logic [1:0] COLOUR_BLUE = 2'h2;
    localparam int unsigned PIX_CNT_W = 9;
    localparam int unsigned TX_SETTLE_MS = 10;
    localparam int unsigned TX_SETTLE_CYCLES = TX_SETTLE_MS * 1000 * CLK_MHZ;
    typedef enum logic [1:0] {AFEHO_BLACK, AFEHO_DUMMY, AFEHO_WHITE}
        afeho_zone_type;
endpackage

// ===== design/afeho_sync.sv
// afeho_sync: two-flop synchroniser for one asynchronous pin.
// assumes nothing of the pin beyond it being a level.
`timescale 1ns/100ps
module afeho_sync
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic pin,
    output logic level
);
    logic meta_q;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_q <= 1'b0;
            level <= 1'b0;
        end
        else
        begin
            meta_q <= pin;
            level <= meta_q;
        end
    end
endmodule

// ===== design/afeho_top.sv
// afeho_top: serial register port and image output path of the front end.
// assumes serial clock and conversion clock are far below clk/4.
`timescale 1ns/100ps
module afeho_top
#(
    parameter int unsigned SETTLE_CYCLES = afeho_pkg::TX_SETTLE_CYCLES
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic serial_select_n,
    input wire logic serial_clock,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_en,
    input wire logic cycle_length_strap,
    input wire logic chip_id_strap,
    input wire logic conversion_clock,
    input wire logic sample_clock_two,
    input wire logic clamp_pin,
    input wire logic [afeho_pkg::DATA_W-1:0] red_odd,
    input wire logic [afeho_pkg::DATA_W-1:0] red_even,
    input wire logic [afeho_pkg::DATA_W-1:0] green_odd,
    input wire logic [afeho_pkg::DATA_W-1:0] green_even,
    input wire logic [afeho_pkg::DATA_W-1:0] blue_odd,
    input wire logic [afeho_pkg::DATA_W-1:0] blue_even,
    output logic [afeho_pkg::DATA_W-1:0] red_out,
    output logic [afeho_pkg::DATA_W-1:0] green_out,
    output logic [afeho_pkg::DATA_W-1:0] blue_out,
    output logic effective_pixel_tag,
    output logic dummy_pixel_tag,
    output logic optical_black_tag,
    output logic ck2_monitor,
    output logic clamp_monitor,
    output logic tx_sync_clock,
    output logic tx_enable,
    output logic tx_stable,
    output logic write_error
);
    import afeho_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic cs_n_s, sck_s, sdi_s, cks_s, ck2_s, clmp_s;
    afeho_sync u_cs (.clk(clk), .nrst(nrst), .pin(serial_select_n),
        .level(cs_n_s));
    afeho_sync u_sck (.clk(clk), .nrst(nrst), .pin(serial_clock),
        .level(sck_s));
    afeho_sync u_sdi (.clk(clk), .nrst(nrst), .pin(serial_in),
        .level(sdi_s));
    afeho_sync u_ck (.clk(clk), .nrst(nrst), .pin(conversion_clock),
        .level(cks_s));
    afeho_sync u_ck2 (.clk(clk), .nrst(nrst), .pin(sample_clock_two),
        .level(ck2_s));
    afeho_sync u_clp (.clk(clk), .nrst(nrst), .pin(clamp_pin),
        .level(clmp_s));
    // straps are pins too; a mid-run change must not glitch the decode
    logic len_s, id_s;
    afeho_sync u_len (.clk(clk), .nrst(nrst), .pin(cycle_length_strap),
        .level(len_s));
    afeho_sync u_id (.clk(clk), .nrst(nrst), .pin(chip_id_strap),
        .level(id_s));

    logic sck_q, cks_q, cs_n_q;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sck_q <= 1'b0;
            cks_q <= 1'b0;
            cs_n_q <= 1'b1;
        end
        else
        begin
            sck_q <= sck_s;
            cks_q <= cks_s;
            cs_n_q <= cs_n_s;
        end
    end
    wire sck_rise = sck_s & ~sck_q & ~cs_n_s;
    wire sck_fall = ~sck_s & sck_q & ~cs_n_s;
    wire cs_rise = cs_n_s & ~cs_n_q;
    wire ck_rise = cks_s & ~cks_q;
    wire ck_fall = ~cks_s & cks_q;

    ////////////////////////////////////////////////////////////////////////
    // serial port
    logic long_mode;
    assign long_mode = ~len_s;
    logic [BIT_CNT_W-1:0] bit_cnt_q;
    logic [15:0] shift_q;
    logic [7:0] reg_bank_q [NUM_REGS];
    logic [REG_NUM_W-1:0] addr_q;
    logic dir_read_q, id_ok_q;
    logic [BIT_CNT_W-1:0] hdr_len, total_len, ok_max;
    always_comb
    begin
        hdr_len = long_mode ? BIT_CNT_W'(7) : BIT_CNT_W'(6);
        total_len = long_mode ? BIT_CNT_W'(LONG_CYCLES)
                              : BIT_CNT_W'(SHORT_CYCLES);
        ok_max = long_mode ? BIT_CNT_W'(LONG_OK_MAX)
                           : BIT_CNT_W'(SHORT_OK_MAX);
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bit_cnt_q <= '0;
            shift_q <= '0;
        end
        else if (cs_n_s)
            bit_cnt_q <= '0;
        else if (sck_rise)
        begin
            if (bit_cnt_q != '1)
                bit_cnt_q <= bit_cnt_q + 1'b1;
            shift_q <= {shift_q[14:0], sdi_s};
        end
    end

    // header decode: direction and chip id as their bits arrive, register number once it has fully arrived
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dir_read_q <= 1'b0;
            id_ok_q <= 1'b0;
            addr_q <= '0;
        end
        else if (sck_rise && bit_cnt_q == BIT_CNT_W'(0))
        begin
            dir_read_q <= sdi_s;
            id_ok_q <= ~long_mode;
        end
        else if (sck_rise && long_mode && bit_cnt_q == BIT_CNT_W'(1))
            id_ok_q <= (sdi_s == id_s);
        else if (sck_rise && bit_cnt_q == hdr_len - 1'b1)
            addr_q <= {shift_q[3:0], sdi_s};
    end

    // write lands on select rise with count in the accepted window
    logic [BIT_CNT_W-1:0] pend_cnt_q;
    logic [7:0] wdata_q;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            wdata_q <= '0;
        else if (sck_rise && bit_cnt_q == total_len - 1'b1)
            wdata_q <= {shift_q[6:0], sdi_s};
    end
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            pend_cnt_q <= '0;
        else if (!cs_n_s)
            pend_cnt_q <= bit_cnt_q;
    end
    wire wr_ok = cs_rise && !dir_read_q && id_ok_q
        && pend_cnt_q >= total_len && pend_cnt_q <= ok_max;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < NUM_REGS; i++)
                reg_bank_q[i] <= 8'h00;
        end
        else if (wr_ok)
            reg_bank_q[addr_q] <= wdata_q;
    end
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            write_error <= 1'b0;
        else if (cs_rise && !dir_read_q && id_ok_q)
            write_error <= pend_cnt_q > ok_max;
    end

    // read data leaves on falling serial clock during data phase
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            serial_out <= 1'b0;
            serial_out_en <= 1'b0;
        end
        else if (cs_n_s)
            serial_out_en <= 1'b0;
        else if (sck_fall && dir_read_q && id_ok_q
                 && bit_cnt_q >= hdr_len && bit_cnt_q < total_len)
        begin
            serial_out_en <= 1'b1;
            serial_out <= reg_bank_q[addr_q][3'(total_len - 1'b1
                - bit_cnt_q)];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control fields
    logic [7:0] dc;
    logic mux_en, order_even, avg_en, line_go;
    logic [1:0] tpat;
    assign dc = reg_bank_q[REG_DATA_CONTROL];
    assign mux_en = dc[DC_MUX_BIT];
    assign order_even = dc[DC_ORDER_BIT];
    assign avg_en = dc[DC_AVG_BIT];
    assign line_go = dc[DC_START_BIT];
    assign tpat = dc[DC_TEST_LSB-1 -: 2];
    wire tx_off = reg_bank_q[REG_POWER_SAVE][PS_TX_BIT];
    wire [15:0] white_cnt = {reg_bank_q[REG_WHITE_COUNT_HI],
                             reg_bank_q[REG_WHITE_COUNT_LO]};

    ////////////////////////////////////////////////////////////////////////
    // line monitor and pixel counter
    logic [15:0] pix_q;
    logic first_q;
    afeho_zone_type zone;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pix_q <= '0;
            first_q <= 1'b1;
        end
        else if (!line_go)
        begin
            pix_q <= '0;
            first_q <= 1'b1;
        end
        else if (ck_rise)
        begin
            first_q <= 1'b0;
            pix_q <= (pix_q >= 16'(reg_bank_q[REG_PIXEL_BOUNDARY])
                + 16'(reg_bank_q[REG_BLACK_COUNT]) + white_cnt)
                ? '0 : pix_q + 1'b1;
        end
    end
    always_comb
    begin
        if (pix_q < 16'(reg_bank_q[REG_PIXEL_BOUNDARY]))
            zone = AFEHO_BLACK;
        else if (pix_q < 16'(reg_bank_q[REG_PIXEL_BOUNDARY])
                 + 16'(reg_bank_q[REG_BLACK_COUNT]))
            zone = AFEHO_DUMMY;
        else
            zone = AFEHO_WHITE;
    end

    ////////////////////////////////////////////////////////////////////////
    // sample choice per colour
    function automatic logic [9:0] pick(input logic [9:0] odd_s,
        input logic [9:0] even_s, input logic hi_phase,
        input logic nulled, input logic [1:0] colour,
        input logic [9:0] ofs, input logic [8:0] cnt);
        logic odd_slot;
        logic [10:0] sum;
        odd_slot = mux_en ? (hi_phase ^ order_even) : ~order_even;
        sum = {1'b0, odd_s} + {1'b0, even_s};
        if (nulled)
            pick = NULL_CODE;
        else if (tpat == TP_COUNT)
            pick = {cnt, ~odd_slot};
        else if (tpat == TP_COLOUR)
            pick = {colour, cnt[6:0], ~odd_slot};
        else if (tpat == TP_FIXED)
            pick = ofs;
        else if (avg_en)
            pick = sum[10:1];
        else
            pick = odd_slot ? odd_s : even_s;
    endfunction

    wire [8:0] cnt9 = pix_q[8:0];
    wire [9:0] ofs_r = {2'b00, reg_bank_q[REG_OFFSET_RED]};
    wire [9:0] ofs_g = {2'b00, reg_bank_q[REG_OFFSET_GREEN]};
    wire [9:0] ofs_b = {2'b00, reg_bank_q[REG_OFFSET_BLUE]};

    ////////////////////////////////////////////////////////////////////////
    // transmitter settle timer
    logic [31:0] settle_q;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            settle_q <= '0;
            tx_stable <= 1'b0;
        end
        else if (tx_off)
        begin
            settle_q <= '0;
            tx_stable <= 1'b0;
        end
        else if (settle_q < SETTLE_CYCLES)
            settle_q <= settle_q + 1'b1;
        else
            tx_stable <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // output lanes, updated on each conversion clock edge while the transmitter is on
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            red_out <= NULL_CODE;
            green_out <= NULL_CODE;
            blue_out <= NULL_CODE;
            effective_pixel_tag <= 1'b0;
            dummy_pixel_tag <= 1'b0;
            optical_black_tag <= 1'b0;
            ck2_monitor <= 1'b0;
            clamp_monitor <= 1'b0;
            tx_sync_clock <= 1'b0;
            tx_enable <= 1'b0;
        end
        else
        begin
            tx_enable <= ~tx_off;
            if (tx_off)
                tx_sync_clock <= 1'b0;
            else if (ck_rise || ck_fall)
            begin
                tx_sync_clock <= cks_s;
                red_out <= pick(red_odd, red_even, cks_s,
                    dc[DC_NULL_R_BIT], COLOUR_RED, ofs_r, cnt9);
                green_out <= pick(green_odd, green_even, cks_s,
                    dc[DC_NULL_G_BIT], COLOUR_GREEN, ofs_g, cnt9);
                blue_out <= pick(blue_odd, blue_even, cks_s,
                    dc[DC_NULL_B_BIT], COLOUR_BLUE, ofs_b, cnt9);
                effective_pixel_tag <= line_go && zone == AFEHO_WHITE;
                dummy_pixel_tag <= line_go && zone == AFEHO_DUMMY;
                optical_black_tag <= line_go && zone == AFEHO_BLACK;
                ck2_monitor <= ck2_s;
                clamp_monitor <= clmp_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    null_red_a: assert property (@(posedge clk) disable iff (!nrst)
        (dc[DC_NULL_R_BIT] && !tx_off && ck_rise) |=> red_out == NULL_CODE)
        else $error("red null not honoured");
    bit_clear_a: assert property (@(posedge clk) disable iff (!nrst)
        cs_n_s |=> bit_cnt_q == '0)
        else $error("bit counter not cleared");
    short_drop_a: assert property (@(posedge clk) disable iff (!nrst)
        (cs_rise && !dir_read_q && pend_cnt_q < total_len)
        |=> reg_bank_q[addr_q] == $past(reg_bank_q[addr_q]))
        else $error("short write landed");
    id_gate_a: assert property (@(posedge clk) disable iff (!nrst)
        (cs_rise && !id_ok_q) |=> $stable(write_error))
        else $error("foreign chip access acted");
    tx_stop_a: assert property (@(posedge clk) disable iff (!nrst)
        tx_off |=> !tx_enable && !tx_sync_clock)
        else $error("transmitter runs while off");
    line_idle_a: assert property (@(posedge clk) disable iff (!nrst)
        !line_go |=> pix_q == '0)
        else $error("counter runs without start");
    tag_one_a: assert property (@(posedge clk) disable iff (!nrst)
        $onehot0({effective_pixel_tag, dummy_pixel_tag, optical_black_tag}))
        else $error("pixel tags overlap");
    fixed_pat_a: assert property (@(posedge clk) disable iff (!nrst)
        (tpat == TP_FIXED && !dc[DC_NULL_G_BIT] && !tx_off && ck_rise
         && $stable(ofs_g)) |=> green_out == ofs_g)
        else $error("fixed pattern wrong");
endmodule

// ===== sim/afeho_host_model.sv
// afeho_host_model: host side of the serial port and conversion clock.
// assumes clk is the bench clock; all pins change just after its rise.
`timescale 1ns/100ps
module afeho_host_model
(
    input wire logic clk,
    input wire logic long_mode,
    input wire logic serial_out,
    output logic serial_select_n,
    output logic serial_clock,
    output logic serial_in,
    output logic conversion_clock
);
    initial
    begin
        serial_select_n = 1'b1;
        serial_clock = 1'b0;
        serial_in = 1'b0;
        conversion_clock = 1'b0;
        rd_q = 8'h00;
    end

    // read data collected on the data-phase rises of the last access
    logic [7:0] rd_q;

    ////////////////////////////////////////////////////////////////////////
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    // serial clock idles low outside frames; 8 clk per phase gives an 80 ns phase and a 160 ns period
    task automatic access(input logic rd, input logic id,
                          input logic [4:0] num, input logic [7:0] val,
                          input int pulses);
        logic [31:0] bits;
        int i;
        if (long_mode)
            bits = {rd, id, num, 2'h0, val, 15'h7fff};
        else
            bits = {rd, num, 2'h0, val, 16'hffff};
        @(posedge clk);
        serial_select_n <= 1'b0;
        for (i = 0; i < pulses; i++)
        begin
            serial_in <= bits[31-i];
            wait_clk(8);
            serial_clock <= 1'b1;
            if (rd && i >= (long_mode ? 9 : 8))
                rd_q <= {rd_q[6:0], serial_out};
            wait_clk(8);
            serial_clock <= 1'b0;
        end
        wait_clk(8);
        serial_select_n <= 1'b1;
        serial_in <= ~serial_in;
        wait_clk(16);
    endtask

    task automatic conv_set(input logic lvl);
        @(posedge clk);
        conversion_clock <= lvl;
    endtask
endmodule

// ===== sim/afeho_top_tb_top.sv
// afeho_top_tb_top: self-checking bench for the serial port and image path.
// assumes afeho_host_model drives the serial pins and conversion clock.
`timescale 1ns/100ps
module afeho_top_tb_top;
    import afeho_pkg::*;
    localparam int unsigned SETTLE = 50;
    logic clk, nrst, sel_n, sclk, sin, sout, sout_en, len_strap, id_strap;
    logic conv, ck2, clamp, eff, dum, ob, ck2_mon, clamp_mon, sync, tx_en;
    logic tx_stable, werr;
    logic [9:0] r_o, r_e, g_o, g_e, b_o, b_e, r_out, g_out, b_out;
    logic [31:0] seed = 32'h12a7;
    logic [7:0] ofs_r, ofs_g, ofs_b;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;

    afeho_top #(.SETTLE_CYCLES(SETTLE)) u_dut (.clk(clk), .nrst(nrst),
        .serial_select_n(sel_n), .serial_clock(sclk), .serial_in(sin),
        .serial_out(sout), .serial_out_en(sout_en),
        .cycle_length_strap(len_strap), .chip_id_strap(id_strap),
        .conversion_clock(conv), .sample_clock_two(ck2), .clamp_pin(clamp),
        .red_odd(r_o), .red_even(r_e), .green_odd(g_o), .green_even(g_e),
        .blue_odd(b_o), .blue_even(b_e), .red_out(r_out),
        .green_out(g_out), .blue_out(b_out), .effective_pixel_tag(eff),
        .dummy_pixel_tag(dum), .optical_black_tag(ob),
        .ck2_monitor(ck2_mon), .clamp_monitor(clamp_mon),
        .tx_sync_clock(sync), .tx_enable(tx_en), .tx_stable(tx_stable),
        .write_error(werr));
    afeho_host_model u_host (.clk(clk), .long_mode(~len_strap),
        .serial_out(sout),
        .serial_select_n(sel_n), .serial_clock(sclk), .serial_in(sin),
        .conversion_clock(conv));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // priority null, fixed pattern, average, multiplex
    function automatic logic [9:0] expv(logic [7:0] dc, logic [9:0] o,
        logic [9:0] e, logic hi, logic nul, logic [7:0] ofs);
        logic [10:0] s;
        s = ({1'b0, o} + {1'b0, e}) >> 1;
        if (nul)
            return NULL_CODE;
        if (dc[7:6] == TP_FIXED)
            return {2'h0, ofs};
        if (dc[DC_AVG_BIT])
            return s[9:0];
        if (dc[DC_MUX_BIT])
            return (hi ^ dc[DC_ORDER_BIT]) ? o : e;
        return dc[DC_ORDER_BIT] ? e : o;
    endfunction

    task automatic chk(input string what, input logic [9:0] exp,
                       input logic [9:0] got);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic rnd_samples();
        logic [31:0] a, b, c;
        a = xs();
        b = xs();
        c = xs();
        @(posedge clk);
        r_o <= a[9:0];
        r_e <= a[19:10];
        g_o <= b[9:0];
        g_e <= b[19:10];
        b_o <= c[9:0];
        b_e <= c[19:10];
        ck2 <= a[31];
        clamp <= b[31];
    endtask

    // one high and one low conversion phase, all three colours compared
    task automatic pix(input string what, input logic [7:0] dc);
        logic hi;
        int k;
        for (k = 0; k < 2; k++)
        begin
            hi = (k == 0);
            rnd_samples();
            u_host.conv_set(hi);
            repeat (8) @(posedge clk);
            chk("red", expv(dc, r_o, r_e, hi, dc[3], ofs_r), r_out);
            chk("green", expv(dc, g_o, g_e, hi, dc[4], ofs_g), g_out);
            chk("blue", expv(dc, b_o, b_e, hi, dc[5], ofs_b), b_out);
            chk("sync", {9'h0, hi}, {9'h0, sync});
            chk("ck2 mon", {9'h0, ck2}, {9'h0, ck2_mon});
            chk("clamp mon", {9'h0, clamp}, {9'h0, clamp_mon});
            chk("tags", {7'h0, dc[6], 2'b00}, {7'h0, eff, dum, ob});
        end
        $display("test %s dc %h done", what, dc);
    endtask

    task automatic wr(input logic [4:0] num, input logic [7:0] val);
        u_host.access(1'b0, id_strap, num, val, len_strap ? 16 : 17);
    endtask

    // power both down around every mode change
    task automatic set_dc(input logic [7:0] val, input int pulses,
                          input logic id, input logic rd);
        wr(REG_POWER_SAVE, 8'h03);
        u_host.access(rd, id, REG_DATA_CONTROL, val, pulses);
        wr(REG_POWER_SAVE, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 90000)
        begin
            fails++;
            $display("[FAIL] timeout expected done seen hang");
            tally_and_finish();
        end
    end

    initial
    begin
        logic [7:0] cfg[10];
        logic [9:0] held;
        cfg = '{8'h00, 8'h02, 8'h01, 8'h03, 8'h04, 8'h06,
                8'h08, 8'h10, 8'h20, 8'h38};
        nrst = 1'b0;
        len_strap = 1'b0;
        id_strap = 1'b1;
        {r_o, r_e, g_o, g_e, b_o, b_e} = '0;
        ck2 = 1'b0;
        clamp = 1'b0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        chk("reset red", 10'h000, r_out);
        ofs_r = xs();
        ofs_g = xs();
        ofs_b = xs();
        wr(REG_OFFSET_RED, ofs_r);
        wr(REG_OFFSET_GREEN, ofs_g);
        wr(REG_OFFSET_BLUE, ofs_b);
        u_host.access(1'b1, id_strap, REG_OFFSET_RED, 8'h00, 17);
        chk("read ofs", {2'h0, ofs_r}, {2'h0, u_host.rd_q});
        foreach (cfg[i])
        begin
            set_dc(cfg[i], 17, id_strap, 1'b0);
            pix("mode", cfg[i]);
        end
        set_dc(8'hc0, 17, id_strap, 1'b0);
        pix("fixed", 8'hc0);
        set_dc(8'h00, 17, id_strap, 1'b0);
        wr(REG_POWER_SAVE, 8'h01);
        chk("tx enable", 10'h000, {9'h0, tx_en});
        held = r_out;
        rnd_samples();
        u_host.conv_set(1'b1);
        repeat (8) @(posedge clk);
        chk("frozen red", held, r_out);
        chk("sync held", 10'h000, {9'h0, sync});
        u_host.conv_set(1'b0);
        wr(REG_POWER_SAVE, 8'h00);
        chk("not settled", 10'h000, {9'h0, tx_stable});
        repeat (SETTLE + 10) @(posedge clk);
        chk("settled", 10'h001, {9'h0, tx_stable});
        $display("test power save done");
        set_dc(8'h02, 15, id_strap, 1'b0);
        pix("short cancel", 8'h00);
        set_dc(8'h02, 17, ~id_strap, 1'b0);
        pix("id mismatch", 8'h00);
        set_dc(8'h02, 17, id_strap, 1'b1);
        pix("read", 8'h00);
        wr(REG_POWER_SAVE, 8'h03);
        u_host.access(1'b0, id_strap, REG_DATA_CONTROL, 8'h02, 26);
        chk("write error", 10'h001, {9'h0, werr});
        wr(REG_POWER_SAVE, 8'h00);
        pix("overrun", 8'h00);
        set_dc(8'h02, 25, id_strap, 1'b0);
        chk("error clear", 10'h000, {9'h0, werr});
        pix("long tail", 8'h02);
        set_dc(8'h01, 18, id_strap, 1'b0);
        pix("short tail", 8'h01);
        @(posedge clk);
        len_strap <= 1'b1;
        id_strap <= 1'b0;
        set_dc(8'h04, 16, 1'b0, 1'b0);
        pix("sixteen", 8'h04);
        set_dc(8'h02, 14, 1'b0, 1'b0);
        pix("sixteen cancel", 8'h04);
        set_dc(8'h03, 24, 1'b0, 1'b0);
        pix("sixteen tail", 8'h03);
        tally_and_finish();
    end
endmodule
